// File: rtl/pec_unit.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module pec_unit #(
  parameter int BEEP_CYC = pec_pkg::BEEP_CYC_DEF
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pec_pkg::AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  input wire logic [pec_pkg::NSOCK-1:0] sock_present_i,
  input wire logic [pec_pkg::NSOCK-1:0] supply_fault_i,
  input wire logic [pec_pkg::NSOCK-1:0] open_pin_i,
  input wire logic [pec_pkg::NSOCK-1:0] held_high_i,
  input wire logic [pec_pkg::NSOCK-1:0] held_low_i,
  input wire logic [pec_pkg::NSOCK-1:0] program_voltage_limit_i,
  input wire logic [pec_pkg::NSOCK-1:0] verify_fail_i,
  input wire logic [pec_pkg::NSOCK-1:0] blank_ok_i,
  input wire logic start_key_i,
  input wire logic enter_key_i,
  input wire logic clear_key_i,
  input wire logic engine_done_i,
  input wire logic [7:0] sock_data_i,
  output logic [3:0] sock_sel_o,
  output logic [15:0] sock_addr_o,
  output logic sock_rd_o,
  output logic [19:0] ram_addr_o,
  output logic ram_rd_o,
  output logic ram_we_o,
  output logic [8:0] ram_wdata_o,
  input wire logic [8:0] ram_rdata_i,
  output logic engine_go_o,
  output logic [2:0] engine_op_o,
  output logic load_err_lamp_o,
  output logic [pec_pkg::NSOCK-1:0] red_led_o,
  output logic [pec_pkg::NSOCK-1:0] green_led_o,
  output logic beeper_o,
  output logic [3:0] disp_code_o,
  output logic [19:0] disp_val_o,
  output logic [4:0] disp_sock_o,
  output logic erase_prompt_o,
  output logic erase_req_o,
  output logic busy_o
);
  import pec_pkg::*;

  localparam int PW = 8 * NSOCK + 12;

  pec_regs_t r;
  pec_regs_t n;
  logic [PW-1:0] pin_a;
  logic [PW-1:0] sync1;
  logic [PW-1:0] sync2;
  logic [2:0] key_q;
  logic [NSOCK-1:0] pr, sf, op_n, hh, hl, vp, vf, bok;
  logic [2:0] keys;
  logic edone;
  logic [7:0] sdat;
  logic k_start, k_enter, k_clear;

  // even parity over a stored byte
  function automatic logic par(input logic [7:0] b);
    return ^b;
  endfunction

  function automatic logic [4:0] popc(input logic [NSOCK-1:0] m);
    logic [4:0] c;
    c = '0;
    for (int i = 0; i < NSOCK; i++) c = c + 5'(m[i]);
    return c;
  endfunction

  // sockets that belong to a whole group
  function automatic logic [NSOCK-1:0] map_mask(input logic [4:0] set);
    int lim;
    logic [NSOCK-1:0] m;
    lim = (NSOCK / int'(set)) * int'(set);
    m = '0;
    for (int i = 0; i < NSOCK; i++) m[i] = (i < lim);
    return m;
  endfunction

  // present sockets in partly filled or unmapped groups
  function automatic logic [NSOCK-1:0] bad_sets(input logic [NSOCK-1:0] p,
                                               input logic [4:0] set);
    int h;
    logic [NSOCK-1:0] m, g, o;
    m = map_mask(set);
    g = '0;
    o = '0;
    for (int i = 0; i < NSOCK; i++) begin
      h = i - (i % int'(set));
      if (m[i] && p[i] != p[h]) g[h] = 1'b1;
    end
    for (int i = 0; i < NSOCK; i++) begin
      h = i - (i % int'(set));
      o[i] = p[i] & (~m[i] | g[h]);
    end
    return o;
  endfunction

  // lowest active socket at or above from
  function automatic logic [4:0] next_act(input logic [NSOCK-1:0] m, input int from);
    logic [4:0] q;
    q = NO_SOCK;
    for (int i = NSOCK - 1; i >= 0; i--) if (m[i] && i >= from) q = 5'(i);
    return q;
  endfunction

  // highest active socket below from
  function automatic logic [4:0] prev_act(input logic [NSOCK-1:0] m, input int from);
    logic [4:0] q;
    q = NO_SOCK;
    for (int i = 0; i < NSOCK; i++) if (m[i] && i < from) q = 5'(i);
    return q;
  endfunction

  // pin inputs pass two flops; keys give one-cycle press pulses
  assign pin_a = {sock_present_i, supply_fault_i, open_pin_i, held_high_i, held_low_i,
                  program_voltage_limit_i, verify_fail_i, blank_ok_i, start_key_i,
                  enter_key_i, clear_key_i, engine_done_i, sock_data_i};
  assign {pr, sf, op_n, hh, hl, vp, vf, bok, keys, edone, sdat} = sync2;
  assign k_start = keys[2] & ~key_q[2];
  assign k_enter = keys[1] & ~key_q[1];
  assign k_clear = keys[0] & ~key_q[0];

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync1 <= '0;
      sync2 <= '0;
      key_q <= '0;
    end else begin
      sync1 <= pin_a;
      sync2 <= sync1;
      key_q <= keys;
    end
  end

  // next state of the whole unit, bus slave included
  always_comb begin
    logic [19:0] plast;
    logic [NSOCK-1:0] bad, act, vpa;
    logic [15:0] s, m;
    logic [4:0] p;
    logic acc, wr;
    acc = 1'b0;
    wr = 1'b0;
    n = r;
    n.go = 1'b0;
    n.erase_req = 1'b0;
    n.ram_we = 1'b0;
    n.ram_rd = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    plast = (20'h1 << r.log2) - 20'h1;
    bad = bad_sets(pr, r.set_size);
    act = pr & map_mask(r.set_size);
    vpa = vp & r.active;
    s = r.sum + 16'(sdat);
    m = '0;
    p = NO_SOCK;
    if (r.beep_cnt != '0) n.beep_cnt = r.beep_cnt - 21'h1;
    unique case (r.st)
      ST_IDLE, ST_PARITY: begin
      end
      ST_LOAD: begin
        n.wcnt = r.wcnt + 10'h1;
        if (r.wcnt == 10'(LOAD_CYC - 1)) begin
          n.load_err = 1'b1;
          n.st = ST_HALT;
          if (pr == '0) begin
            n.code = C_NONE;
          end else if (sf != '0) begin
            n.code = C_SUPPLY;
            n.red = sf;
          end else if (op_n != '0) begin
            n.code = C_OPEN;
            n.red = op_n;
          end else if (hh != '0) begin
            n.code = C_HIGH;
            n.red = hh;
          end else if (hl != '0) begin
            n.code = C_LOW;
            n.red = hl;
          end else if (r.run && bad != '0) begin
            n.code = C_GROUP;
            n.red = bad;
          end else if (act == '0) begin
            n.code = C_NONE;
          end else begin
            // check passed: only now run the requested operation
            n.load_err = 1'b0;
            n.active = act;
            n.wcnt = '0;
            n.cnt = '0;
            n.sum = '0;
            n.failed = '0;
            if (r.op == OP_PROG) begin
              n.go = 1'b1;
              n.st = ST_PROG0;
            end else if (r.op == OP_BLANK) begin
              n.go = 1'b1;
              n.st = ST_BLANK;
            end else begin
              n.idx = next_act(act, 0);
              n.st = ST_SOCK_RD;
            end
          end
        end
      end
      ST_HALT: begin
        if (k_start || k_enter) begin
          n.st = ST_LOAD;
          n.wcnt = '0;
          n.load_err = 1'b0;
          n.red = '0;
          n.code = C_OK;
        end
      end
      ST_PROG0: begin
        n.wcnt = r.wcnt + 10'h1;
        if (vpa != '0) begin
          n.load_err = 1'b1;
          n.red = vpa;
          n.beep_cnt = 21'(BEEP_CYC);
          n.code = C_VOLT;
          n.st = ST_HALT;
        end else if ((vf & r.active) != '0) begin
          n.red = vf & r.active;
          n.code = C_VERIFY;
          n.load_err = 1'b1;
          n.st = ST_HALT;
        end else if (r.wcnt == 10'(PROG_START_CYC - 1)) begin
          n.st = ST_PROG;
        end
      end
      ST_PROG: begin
        n.active = r.active & ~vpa;
        n.failed = r.failed | vpa;
        if (edone) begin
          n.npass = popc(r.active & ~vpa);
          n.nfail = popc(r.failed | vpa);
          n.green = r.active & ~vpa;
          n.red = r.failed | vpa;
          n.code = C_PASSFAIL;
          n.st = ST_IDLE;
        end
      end
      ST_BLANK: begin
        if (edone) begin
          n.npass = popc(r.active & bok);
          n.nfail = popc(r.active & ~bok);
          n.green = r.active & bok;
          n.red = r.active & ~bok;
          n.code = C_PASSFAIL;
          n.st = ST_IDLE;
          if (r.erasable) begin
            n.erase_prompt = 1'b1;
            n.code = C_ERASE_Q;
            n.st = ST_ERASE;
          end
        end
      end
      ST_ERASE: begin
        if (k_enter || k_clear) begin
          n.erase_req = k_enter;
          n.erase_prompt = 1'b0;
          n.code = C_PASSFAIL;
          n.st = ST_IDLE;
        end
      end
      ST_SOCK_RD: begin
        n.wcnt = r.wcnt + 10'h1;
        if (r.wcnt == 10'(SOCK_WAIT - 1)) begin
          n.wcnt = '0;
          n.sum = s;
          n.cnt = r.cnt + 20'h1;
          if (r.cnt == plast) begin
            n.val = 20'(s);
            n.sock = r.idx + 5'h1;
            n.code = C_SOCKSUM;
            n.last_shown = (next_act(r.active, int'(r.idx) + 1) == NO_SOCK);
            n.st = ST_SOCK_SHOW;
          end
        end
      end
      ST_SOCK_SHOW: begin
        n.cnt = '0;
        n.sum = '0;
        n.wcnt = '0;
        if (k_enter) begin
          if (r.last_shown) begin
            n.st = ST_IDLE;
          end else begin
            n.idx = next_act(r.active, int'(r.idx) + 1);
            n.st = ST_SOCK_RD;
          end
        end else if (k_clear && !r.last_shown) begin
          p = prev_act(r.active, int'(r.idx));
          if (p != NO_SOCK) begin
            n.idx = p;
            n.st = ST_SOCK_RD;
          end
        end
      end
      ST_SET_RD: begin
        n.ram_rd = 1'b1;
        n.ram_addr = (20'(r.idx) << r.log2) + r.cnt;
        n.st = ST_RAM_WAIT;
      end
      ST_RAM_WAIT: begin
        n.st = ST_SET_CHK;
      end
      ST_SET_CHK: begin
        s = r.sum + 16'(ram_rdata_i[7:0]);
        if (par(ram_rdata_i[7:0]) != ram_rdata_i[8]) begin
          n.code = C_PARITY;
          n.st = ST_PARITY;
        end else if (r.cnt == plast) begin
          m = (r.set_size > 5'h1) ? (s ^ (16'h1 << r.idx)) : s;
          n.total = r.total + 20'(m);
          n.cnt = '0;
          n.sum = '0;
          n.idx = r.idx + 5'h1;
          n.st = ST_SET_RD;
          if (r.idx + 5'h1 == r.set_size) begin
            n.val = r.total + 20'(m);
            n.code = C_SETSUM;
            n.st = ST_IDLE;
          end
        end else begin
          n.sum = s;
          n.cnt = r.cnt + 20'h1;
          n.st = ST_SET_RD;
        end
      end
    endcase

    // APB: one wait state, write takes effect when pready is seen
    acc = psel_i & penable_i & ~r.pready;
    wr = psel_i & penable_i & r.pready & pwrite_i;
    if (acc) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      unique case (paddr_i)
        OFF_CMD: n.prdata = 32'({r.run, r.op});
        OFF_CFG: n.prdata = 32'({r.erasable, 3'h0, r.log2, 3'h0, r.set_size});
        OFF_STAT: n.prdata = 32'({r.type_ok, r.st == ST_PARITY, r.busy, r.code});
        OFF_RES: n.prdata = 32'({r.sock, 4'h0, r.val});
        OFF_CNT: n.prdata = 32'({r.nfail, 3'h0, r.npass});
        OFF_MASK: n.prdata = {r.red, r.active};
        OFF_RADDR: n.prdata = 32'(r.raddr);
        OFF_RDATA: n.prdata = '0;
        default: begin
          n.prdata = '0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (wr && r.st == ST_IDLE) begin
      if (paddr_i == OFF_CMD) begin
        n.op = pwdata_i[2:0];
        n.run = pwdata_i[CMD_RUN];
        n.code = C_OK;
        n.red = '0;
        n.green = '0;
        n.load_err = 1'b0;
        n.wcnt = '0;
        n.cnt = '0;
        n.sum = '0;
        n.total = '0;
        n.idx = '0;
        if (pwdata_i[2:0] == '0 || pwdata_i[2:0] > OP_SETSUM) begin
          n.op = r.op;
        end else if (!r.type_ok) begin
          n.code = C_ORDER;
        end else if (pwdata_i[2:0] == OP_SETSUM) begin
          n.st = ST_SET_RD;
        end else begin
          n.st = ST_LOAD;
        end
      end
      if (paddr_i == OFF_CFG) begin
        if (pwdata_i[4:0] != '0 && pwdata_i[4:0] <= SET_MAX &&
            pwdata_i[CFG_LOG2 +: 5] <= LOG2_MAX) begin
          n.set_size = pwdata_i[4:0];
          n.log2 = pwdata_i[CFG_LOG2 +: 5];
          n.erasable = pwdata_i[CFG_EE];
          n.type_ok = 1'b1;
        end
      end
      if (paddr_i == OFF_RADDR) n.raddr = pwdata_i[19:0];
      if (paddr_i == OFF_RDATA) begin
        n.ram_we = 1'b1;
        n.ram_addr = r.raddr;
        n.ram_wdata = {par(pwdata_i[7:0]), pwdata_i[7:0]};
        n.raddr = r.raddr + 20'h1;
      end
    end
    n.sock_rd = (n.st == ST_SOCK_RD);
    n.busy = (n.st != ST_IDLE);
    n.beep = (n.beep_cnt != '0);
  end

  // register stage; reset loads SET_DEF and LOG2_DEF and clears the rest, but never touches buffer RAM
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.set_size <= SET_DEF;
      r.log2 <= LOG2_DEF;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the register stage
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;
  assign prdata_o = r.prdata;
  assign sock_sel_o = r.idx[3:0];
  assign sock_addr_o = r.cnt[15:0];
  assign sock_rd_o = r.sock_rd;
  assign ram_addr_o = r.ram_addr;
  assign ram_rd_o = r.ram_rd;
  assign ram_we_o = r.ram_we;
  assign ram_wdata_o = r.ram_wdata;
  assign engine_go_o = r.go;
  assign engine_op_o = r.op;
  assign load_err_lamp_o = r.load_err;
  assign red_led_o = r.red;
  assign green_led_o = r.green;
  assign beeper_o = r.beep;
  assign disp_code_o = r.code;
  assign disp_val_o = r.val;
  assign disp_sock_o = r.sock;
  assign erase_prompt_o = r.erase_prompt;
  assign erase_req_o = r.erase_req;
  assign busy_o = r.busy;
endmodule

// File: rtl/pec_pkg.sv
package pec_pkg;
  localparam int NSOCK = 16;
  localparam int AW = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_RES = 8'h0C;
  localparam logic [7:0] OFF_CNT = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_RADDR = 8'h18;
  localparam logic [7:0] OFF_RDATA = 8'h1C;
  // field positions
  localparam int CMD_RUN = 3;
  localparam int CFG_LOG2 = 8;
  localparam int CFG_EE = 16;
  localparam int RES_SOCK = 24;
  localparam int CNT_FAIL = 8;
  localparam int MASK_RED = 16;
  // reset values and limits
  localparam logic [4:0] SET_DEF = 5'h01;
  localparam logic [4:0] SET_MAX = 5'h10;
  localparam logic [4:0] LOG2_DEF = 5'h0C;
  localparam logic [4:0] LOG2_MAX = 5'h10;
  localparam logic [4:0] NO_SOCK = 5'h10;
  // commands
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_BLANK = 3'h2;
  localparam logic [2:0] OP_SOCKSUM = 3'h3;
  localparam logic [2:0] OP_SETSUM = 3'h4;
  // display codes
  localparam logic [3:0] C_OK = 4'h0;
  localparam logic [3:0] C_NONE = 4'h1;
  localparam logic [3:0] C_SUPPLY = 4'h2;
  localparam logic [3:0] C_OPEN = 4'h3;
  localparam logic [3:0] C_HIGH = 4'h4;
  localparam logic [3:0] C_LOW = 4'h5;
  localparam logic [3:0] C_GROUP = 4'h6;
  localparam logic [3:0] C_ORDER = 4'h7;
  localparam logic [3:0] C_VOLT = 4'h8;
  localparam logic [3:0] C_VERIFY = 4'h9;
  localparam logic [3:0] C_PARITY = 4'hA;
  localparam logic [3:0] C_PASSFAIL = 4'hB;
  localparam logic [3:0] C_SOCKSUM = 4'hC;
  localparam logic [3:0] C_SETSUM = 4'hD;
  localparam logic [3:0] C_ERASE_Q = 4'hE;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int LOAD_SETTLE_NS = 2000;
  localparam int LOAD_CYC = (LOAD_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PROG_START_US = 50;
  localparam int PROG_START_CYC = PROG_START_US * (CLK_HZ / 1_000_000);
  localparam int BEEP_MS = 200;
  localparam int BEEP_CYC_DEF = BEEP_MS * (CLK_HZ / 1000);
  localparam int SOCK_WAIT = 4;

  typedef enum logic [3:0] {
    ST_IDLE, ST_LOAD, ST_HALT, ST_PROG0, ST_PROG, ST_BLANK, ST_ERASE,
    ST_SOCK_RD, ST_SOCK_SHOW, ST_SET_RD, ST_RAM_WAIT, ST_SET_CHK, ST_PARITY
  } pec_state_t;

  typedef struct packed {
    pec_state_t st;
    logic [2:0] op;
    logic run;
    logic [4:0] set_size;
    logic [4:0] log2;
    logic type_ok;
    logic erasable;
    logic [NSOCK-1:0] active;
    logic [NSOCK-1:0] red;
    logic [NSOCK-1:0] green;
    logic [NSOCK-1:0] failed;
    logic load_err;
    logic [20:0] beep_cnt;
    logic beep;
    logic [3:0] code;
    logic [19:0] val;
    logic [4:0] sock;
    logic [4:0] npass;
    logic [4:0] nfail;
    logic [19:0] cnt;
    logic [9:0] wcnt;
    logic [15:0] sum;
    logic [19:0] total;
    logic [4:0] idx;
    logic last_shown;
    logic [19:0] raddr;
    logic ram_we;
    logic ram_rd;
    logic [19:0] ram_addr;
    logic [8:0] ram_wdata;
    logic sock_rd;
    logic go;
    logic erase_prompt;
    logic erase_req;
    logic busy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pec_regs_t;
endpackage

// File: verification/pec_chk.sv
`timescale 1ns/100ps
// port-level checks of fault display, parity and reset behaviour
module pec_chk (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic load_err_lamp_o,
  input wire logic [pec_pkg::NSOCK-1:0] red_led_o,
  input wire logic beeper_o,
  input wire logic [3:0] disp_code_o,
  input wire logic [4:0] disp_sock_o,
  input wire logic engine_go_o,
  input wire logic busy_o,
  input wire logic ram_we_o,
  input wire logic [8:0] ram_wdata_o
);
  import pec_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  property p_lamp_code;
    $rose(load_err_lamp_o) |-> disp_code_o != C_OK && disp_code_o != C_PASSFAIL;
  endproperty
  a_lamp_code: assert property (p_lamp_code)
    else $error("lamp lit without a fault code");
  property p_beep_volt;
    $rose(beeper_o) |-> disp_code_o == C_VOLT && load_err_lamp_o && red_led_o != '0;
  endproperty
  a_beep_volt: assert property (p_beep_volt)
    else $error("beeper without voltage fault display");
  property p_halt;
    load_err_lamp_o |-> !engine_go_o;
  endproperty
  a_halt: assert property (p_halt)
    else $error("engine started while fault shown");
  property p_check_first;
    $rose(engine_go_o) |-> $past(busy_o, 16);
  endproperty
  a_check_first: assert property (p_check_first)
    else $error("engine started without socket check");
  property p_parity_bit;
    ram_we_o |-> ram_wdata_o[8] == ^ram_wdata_o[7:0];
  endproperty
  a_parity_bit: assert property (p_parity_bit)
    else $error("bad parity bit on buffer write");
  property p_parity_lock;
    disp_code_o == C_PARITY |=> disp_code_o == C_PARITY;
  endproperty
  a_parity_lock: assert property (p_parity_lock)
    else $error("parity lock left without reset");
  property p_reset_clear;
    $fell(reset_i) |-> !busy_o && !load_err_lamp_o && disp_code_o == C_OK && red_led_o == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not cleared by reset");
  property p_order_idle;
    $rose(disp_code_o == C_ORDER) |-> !busy_o;
  endproperty
  a_order_idle: assert property (p_order_idle)
    else $error("order error without return to idle");
  property p_sock_num;
    disp_code_o == C_SOCKSUM |-> disp_sock_o >= 5'h01 && disp_sock_o <= 5'h10;
  endproperty
  a_sock_num: assert property (p_sock_num)
    else $error("socket sum shown with bad socket number");
endmodule

// File: verification/pec_far.sv
`timescale 1ns/100ps
// sockets holding parts plus the 9-bit buffer RAM behind the unit
module pec_far (
  input wire logic sys_clk_i,
  input wire logic [3:0] sock_sel_i,
  input wire logic [15:0] sock_addr_i,
  input wire logic sock_rd_i,
  output logic [7:0] sock_data_o,
  input wire logic [19:0] ram_addr_i,
  input wire logic ram_rd_i,
  input wire logic ram_we_i,
  input wire logic [8:0] ram_wdata_i,
  output logic [8:0] ram_rdata_o,
  input wire logic bad_parity_i
);
  logic [8:0] mem [int];
  initial begin
    sock_data_o = 8'h00;
    ram_rdata_o = 9'h000;
  end
  // part byte is socket index in the high nibble plus address; toggles when idle
  always @(posedge sys_clk_i) begin
    if (sock_rd_i) begin
      sock_data_o <= {sock_sel_i, 4'h0} + sock_addr_i[7:0];
    end else begin
      sock_data_o <= ~sock_data_o;
    end
  end
  // word kept with its parity bit, returned one clock after the read strobe
  always @(posedge sys_clk_i) begin
    if (ram_we_i) begin
      mem[ram_addr_i] = ram_wdata_i;
    end
    if (ram_rd_i) begin
      ram_rdata_o <= (mem.exists(ram_addr_i) ? mem[ram_addr_i] : 9'h000)
        ^ {bad_parity_i, 8'h00};
    end else begin
      ram_rdata_o <= ~ram_rdata_o;
    end
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import pec_pkg::*;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00, sdata;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic [15:0] present = '0, supply = '0, open_pin = '0, held_hi = '0, held_lo = '0;
  logic [15:0] vlim = '0, vfail = '0, bok = '0, red, green, saddr;
  logic start_k = 1'b0, enter_k = 1'b0, clear_k = 1'b0, done = 1'b0, bad_par = 1'b0;
  logic pready_o, pslverr_o, srd, rrd, rwe, go, lamp, beep, prompt, ereq, busy;
  logic [3:0] ssel, code;
  logic [19:0] raddr, dval;
  logic [8:0] rwdata, rrdata;
  logic [2:0] eop;
  logic [4:0] dsock, ereq_n = 5'h00;
  int err_total = 0, cmp_count = 0;
  logic [32:0] expq [$];

  pec_unit #(.BEEP_CYC(10)) DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .sock_present_i(present),
    .supply_fault_i(supply), .open_pin_i(open_pin), .held_high_i(held_hi), .held_low_i(held_lo),
    .program_voltage_limit_i(vlim), .verify_fail_i(vfail), .blank_ok_i(bok),
    .start_key_i(start_k), .enter_key_i(enter_k), .clear_key_i(clear_k), .engine_done_i(done),
    .sock_data_i(sdata), .sock_sel_o(ssel), .sock_addr_o(saddr), .sock_rd_o(srd),
    .ram_addr_o(raddr), .ram_rd_o(rrd), .ram_we_o(rwe), .ram_wdata_o(rwdata),
    .ram_rdata_i(rrdata), .engine_go_o(go), .engine_op_o(eop), .load_err_lamp_o(lamp),
    .red_led_o(red), .green_led_o(green), .beeper_o(beep), .disp_code_o(code),
    .disp_val_o(dval), .disp_sock_o(dsock), .erase_prompt_o(prompt), .erase_req_o(ereq),
    .busy_o(busy));
  pec_far u_far (.sys_clk_i(sys_clk_i), .sock_sel_i(ssel), .sock_addr_i(saddr),
    .sock_rd_i(srd), .sock_data_o(sdata), .ram_addr_i(raddr), .ram_rd_i(rrd), .ram_we_i(rwe),
    .ram_wdata_i(rwdata), .ram_rdata_o(rrdata), .bad_parity_i(bad_par));

  always #50 sys_clk_i = ~sys_clk_i;
  // read results are compared against the oldest queued note
  always @(posedge sys_clk_i) begin
    if (pready_o === 1'b1 && pwrite_i === 1'b0) begin
      if (expq.size() == 0) chk(1, 0);
      else chk({pslverr_o, prdata_o}, expq.pop_front());
    end
    if (ereq === 1'b1) ereq_n <= ereq_n + 5'h01;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic key(input int k);
    @(posedge sys_clk_i);
    start_k <= (k == 0);
    enter_k <= (k == 1);
    clear_k <= (k == 2);
    repeat (4) @(posedge sys_clk_i);
    {start_k, enter_k, clear_k} <= 3'b000;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic idle();
    repeat (3) @(posedge sys_clk_i);
    wait (busy === 1'b0);
    @(posedge sys_clk_i);
  endtask
  task automatic till_go();
    wait (go === 1'b1);
    @(posedge sys_clk_i);
  endtask
  task automatic setsum(input logic [31:0] cfg, input logic [19:0] e);
    apb(1'b1, OFF_CFG, cfg);
    apb(1'b1, OFF_CMD, 32'h4);
    idle();
    chk({code, dval}, {C_SETSUM, e});
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    err_total++;
    report_and_stop();
  end

  initial begin
    int k;
    logic [15:0] ok;
    logic [4:0] np, n;
    logic [19:0] tot;
    logic [15:0] bs [3];
    logic [7:0] b;
    void'($urandom(32'hFA9A5CBB));
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(OFF_STAT, 33'h0);
    rd(8'h20, {1'b1, 32'h0});
    apb(1'b1, OFF_CMD, 32'h1);
    rd(OFF_STAT, 33'h7);
    apb(1'b1, OFF_CFG, 32'h0203);
    // each socket fault kind, then recovery and an erased-state check
    for (k = 0; k < 6; k++) begin
      present <= (k == 0) ? 16'h0 : (k == 5) ? 16'h0003 : 16'h01FF;
      supply <= (k == 1) ? 16'h0004 : 16'h0;
      open_pin <= (k == 2) ? 16'h0004 : 16'h0;
      held_hi <= (k == 3) ? 16'h0004 : 16'h0;
      held_lo <= (k == 4) ? 16'h0004 : 16'h0;
      apb(1'b1, OFF_CMD, (k == 5) ? 32'hA : 32'h2);
      wait (lamp === 1'b1);
      @(posedge sys_clk_i);
      rd(OFF_STAT, 33'h51 + 33'(k));
      if (k inside {[1:4]}) chk(red, 16'h0004);
      ok = 16'($urandom);
      {supply, open_pin, held_hi, held_lo} <= '0;
      present <= 16'h01FF;
      bok <= ok;
      key(k % 2);
      till_go();
      chk(eop, OP_BLANK);
      done <= 1'b1;
      idle();
      done <= 1'b0;
      np = 5'($countones(ok & 16'h01FF));
      chk({green, red}, {ok & 16'h01FF, ~ok & 16'h01FF});
      rd(OFF_CNT, {1'b0, 19'h0, 5'd9 - np, 3'h0, np});
    end
    apb(1'b1, OFF_CFG, 32'h10203);
    apb(1'b1, OFF_CMD, 32'h2);
    till_go();
    done <= 1'b1;
    wait (prompt === 1'b1);
    @(posedge sys_clk_i);
    done <= 1'b0;
    chk(code, C_ERASE_Q);
    key(1);
    idle();
    chk(ereq_n, 5'h01);
    // voltage fault early, then late, then an early verify mismatch
    apb(1'b1, OFF_CFG, 32'h0203);
    apb(1'b1, OFF_CMD, 32'h1);
    till_go();
    vlim <= 16'h0002;
    wait (lamp === 1'b1);
    @(posedge sys_clk_i);
    chk({beep, red}, {1'b1, 16'h0002});
    rd(OFF_STAT, 33'h58);
    vlim <= '0;
    key(1);
    till_go();
    repeat (600) @(posedge sys_clk_i);
    vlim <= 16'h0008;
    repeat (20) @(posedge sys_clk_i);
    chk({lamp, beep}, 2'b00);
    vlim <= '0;
    done <= 1'b1;
    idle();
    done <= 1'b0;
    rd(OFF_CNT, 33'h0108);
    apb(1'b1, OFF_CMD, 32'h1);
    till_go();
    vfail <= 16'h0001;
    wait (lamp === 1'b1);
    @(posedge sys_clk_i);
    chk({code, red}, {C_VERIFY, 16'h0001});
    vfail <= '0;
    key(0);
    till_go();
    done <= 1'b1;
    idle();
    done <= 1'b0;
    // socket sums over three sockets: back one, then clear refused after the last
    present <= 16'h0007;
    apb(1'b1, OFF_CMD, 32'h3);
    for (k = 0; k < 6; k++) begin
      if (k > 0) key((k == 2 || k == 5) ? 2 : 1);
      wait (code === C_SOCKSUM && srd === 1'b0);
      n = (k == 0 || k == 2) ? 5'h01 : (k < 4) ? 5'h02 : 5'h03;
      chk({dsock, dval}, {n, 20'h00006 + 20'h40 * 20'(n - 5'h01)});
    end
    key(1);
    idle();
    // set checksum over random buffer contents
    apb(1'b1, OFF_RADDR, 32'h0);
    bs = '{default: 16'h0};
    for (k = 0; k < 12; k++) begin
      b = 8'($urandom);
      apb(1'b1, OFF_RDATA, {24'h0, b});
      bs[k / 4] += {8'h0, b};
    end
    tot = 20'h0;
    for (k = 0; k < 3; k++) tot += {4'h0, bs[k] ^ (16'h1 << k)};
    setsum(32'h0203, tot);
    setsum(32'h0200, tot);
    setsum(32'h0211, tot);
    setsum(32'h0201, {4'h0, bs[0]});
    bad_par <= 1'b1;
    apb(1'b1, OFF_CMD, 32'h4);
    wait (code === C_PARITY);
    @(posedge sys_clk_i);
    bad_par <= 1'b0;
    apb(1'b1, OFF_CMD, 32'h4);
    rd(OFF_STAT, 33'h7A);
    reset_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(OFF_STAT, 33'h0);
    setsum(32'h0203, tot);
    report_and_stop();
  end
endmodule

bind pec_unit pec_chk u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .load_err_lamp_o(load_err_lamp_o), .red_led_o(red_led_o), .beeper_o(beeper_o),
  .disp_code_o(disp_code_o), .disp_sock_o(disp_sock_o), .engine_go_o(engine_go_o),
  .busy_o(busy_o), .ram_we_o(ram_we_o), .ram_wdata_o(ram_wdata_o));
